/* hdl/tbp_port_map.svh */
`ifndef TBP_PORT_MAP_SVH
`define TBP_PORT_MAP_SVH

// ==========================================================
// Register byte addresses
`define TBP_ADDR_PIN_DATA     32'hfffff406
`define TBP_ADDR_DIRECTION    32'hfffff426
`define TBP_ADDR_ALT_SELECT   32'hfffff466
`define TBP_ADDR_PORT_ALT     32'hfffff446
`define TBP_ADDR_DRIVE_TYPE   32'hfffffc66
`define TBP_ADDR_PULLUP       32'hfffffc46

// ==========================================================
// Field positions and reset values
`define TBP_NPINS             3
`define TBP_PIN_RX            0
`define TBP_PIN_TX            1
`define TBP_PIN_SCK           2
`define TBP_DRIVE_TYPE_MASK   8'h06
`define TBP_RST_DIRECTION     8'hff
`define TBP_RST_ALT_SELECT    8'h00
`define TBP_RST_PORT_ALT      8'h00
`define TBP_RST_DRIVE_TYPE    8'h00
`define TBP_RST_PULLUP        8'h00
`define TBP_RST_LATCH         8'h00

`endif

/* hdl/tbp_pkg.sv */
package tbp_pkg;

  // ==========================================================
  // Register selector
  typedef enum logic [6:0] {
    TBP_REG_NONE  = 7'h01,
    TBP_REG_DATA  = 7'h02,
    TBP_REG_DIR   = 7'h04,
    TBP_REG_ALTS  = 7'h08,
    TBP_REG_PMODE = 7'h10,
    TBP_REG_DRV   = 7'h20,
    TBP_REG_PULL  = 7'h40
  } tbp_reg_t;

  // Bus access kind for the register write merge
  typedef enum logic [1:0] {
    TBP_ACC_BYTE = 2'h0,
    TBP_ACC_BIT  = 2'h1
  } tbp_acc_t;

endpackage

/* hdl/tbp_pin_cell.sv */
`timescale 1ns/1ps
// ==========================================================
// One pin: mux between port latch and peripheral, drive type
module tbp_pin_cell (
  // Configuration
  input  wire logic port_alt_in,
  input  wire logic dir_in,
  input  wire logic open_drain_in,
  input  wire logic latch_in,
  // Peripheral side
  input  wire logic periph_out_in,
  input  wire logic periph_oe_in,
  // Pad side
  output logic      pad_o_out,
  output logic      pad_oe_out
);

  logic drive_val;
  logic drive_en;

  always_comb begin
    if (port_alt_in) begin
      drive_val = periph_out_in;
      drive_en  = periph_oe_in;
    end else begin
      drive_val = latch_in;
      drive_en  = ~dir_in;
    end
    pad_o_out  = drive_val;
    pad_oe_out = drive_en & (~open_drain_in | ~drive_val);
  end

endmodule

/* hdl/tbp_port.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// - Three pins, each individually input or output.
// - Data register 8 bits, pins at bits 0-2; read pins, write levels; the code reads the latch back for output pins.
// - Direction register: 0 makes an output, upper bits 3-7 read 1.
// - Mode-control register picks port operation or alternate function per pin.
// - Function select: pin0 serial-1 in or UART rx; pin1 serial-1 out or UART tx.
// - Pin 2 alternate is serial unit 0 clock; pins 0,1 carry data.
// - Output-type bits 1,2: 0 push-pull, 1 N-channel open drain.
// - Open drain selectable on the serial-1 out / UART transmit pin.
// - Each pin has a software-enabled pull-up via a pull-up register.
// - All registers take 8-bit and single-bit reads and writes.
`include "tbp_port_map.svh"

module tbp_port #(
  parameter int NPINS = `TBP_NPINS
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  // Register bus
  input  wire logic [31:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        bit_acc_in,
  input  wire logic [2:0]  bit_sel_in,
  output logic      [7:0]  rdata_out,
  // Pins
  input  wire logic [2:0]  pin_in,
  output logic      [2:0]  pin_out,
  output logic      [2:0]  pin_oe_out,
  output logic      [2:0]  pullup_en_out,
  // Peripherals
  input  wire logic        serial1_data_out_in,
  input  wire logic        serial1_data_oe_in,
  input  wire logic        uart0_transmit_in,
  input  wire logic        serial0_clock_out_in,
  input  wire logic        serial0_clock_oe_in,
  output logic             serial1_data_in_out,
  output logic             uart0_receive_out,
  output logic             serial0_clock_in_out
);

  // ==========================================================
  // Register state
  logic [7:0] port_pin_data;
  logic [7:0] port_direction;
  logic [7:0] alternate_mode_select;
  logic [7:0] port_or_alternate_control;
  logic [7:0] output_drive_type;
  logic [7:0] pullup_option;
  logic [7:0] next_port_pin_data;
  logic [7:0] next_port_direction;
  logic [7:0] next_alternate_mode_select;
  logic [7:0] next_port_or_alternate_control;
  logic [7:0] next_output_drive_type;
  logic [7:0] next_pullup_option;
  logic [7:0] next_rdata;
  logic [7:0] mask_lo;
  logic [7:0] read_val;
  logic [7:0] pin_read;
  tbp_pkg::tbp_reg_t sel;
  tbp_pkg::tbp_acc_t acc;

  function automatic tbp_pkg::tbp_reg_t decode(input logic [31:0] a);
    case (a)
      `TBP_ADDR_PIN_DATA:   decode = tbp_pkg::TBP_REG_DATA;
      `TBP_ADDR_DIRECTION:  decode = tbp_pkg::TBP_REG_DIR;
      `TBP_ADDR_ALT_SELECT: decode = tbp_pkg::TBP_REG_ALTS;
      `TBP_ADDR_PORT_ALT:   decode = tbp_pkg::TBP_REG_PMODE;
      `TBP_ADDR_DRIVE_TYPE: decode = tbp_pkg::TBP_REG_DRV;
      `TBP_ADDR_PULLUP:     decode = tbp_pkg::TBP_REG_PULL;
      default:              decode = tbp_pkg::TBP_REG_NONE;
    endcase
  endfunction

  // Byte write or single-bit write merged into the old value
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input tbp_pkg::tbp_acc_t a, input logic [2:0] b,
                                       input logic [7:0] keep);
    logic [7:0] v;
    v = old;
    if (a == tbp_pkg::TBP_ACC_BIT) begin
      v[b] = wd[0];
    end else begin
      v = wd;
    end
    merge = v & keep;
  endfunction

  assign mask_lo = 8'h07;

  // ==========================================================
  // Pin read value: latch in output mode, pin level in input mode
  always_comb begin
    pin_read = 8'h00;
    for (int i = 0; i < NPINS; i++) begin
      pin_read[i] = port_direction[i] ? pin_in[i] : port_pin_data[i];
    end
  end

  always_comb begin
    sel = decode(addr_in);
    acc = bit_acc_in ? tbp_pkg::TBP_ACC_BIT : tbp_pkg::TBP_ACC_BYTE;
    next_port_pin_data             = port_pin_data;
    next_port_direction            = port_direction;
    next_alternate_mode_select     = alternate_mode_select;
    next_port_or_alternate_control = port_or_alternate_control;
    next_output_drive_type         = output_drive_type;
    next_pullup_option             = pullup_option;
    case (sel)
      tbp_pkg::TBP_REG_DATA:  read_val = pin_read;
      tbp_pkg::TBP_REG_DIR:   read_val = port_direction;
      tbp_pkg::TBP_REG_ALTS:  read_val = alternate_mode_select;
      tbp_pkg::TBP_REG_PMODE: read_val = port_or_alternate_control;
      tbp_pkg::TBP_REG_DRV:   read_val = output_drive_type;
      tbp_pkg::TBP_REG_PULL:  read_val = pullup_option;
      default:                read_val = 8'h00;
    endcase
    if (acc == tbp_pkg::TBP_ACC_BIT) begin
      next_rdata = {7'h00, read_val[bit_sel_in]};
    end else begin
      next_rdata = read_val;
    end
    if (!rd_in) begin
      next_rdata = rdata_out;
    end
    if (wr_in) begin
      case (sel)
        tbp_pkg::TBP_REG_DATA: begin
          next_port_pin_data = merge(port_pin_data, wdata_in, acc, bit_sel_in,
                                     mask_lo);
        end
        tbp_pkg::TBP_REG_DIR: begin
          next_port_direction = merge(port_direction, wdata_in, acc, bit_sel_in,
                                      mask_lo) | 8'hf8;
        end
        tbp_pkg::TBP_REG_ALTS: begin
          next_alternate_mode_select = merge(alternate_mode_select, wdata_in, acc,
                                             bit_sel_in, 8'h03);
        end
        tbp_pkg::TBP_REG_PMODE: begin
          next_port_or_alternate_control = merge(port_or_alternate_control, wdata_in,
                                                 acc, bit_sel_in, mask_lo);
        end
        tbp_pkg::TBP_REG_DRV: begin
          next_output_drive_type = merge(output_drive_type, wdata_in, acc, bit_sel_in,
                                         `TBP_DRIVE_TYPE_MASK);
        end
        tbp_pkg::TBP_REG_PULL: begin
          next_pullup_option = merge(pullup_option, wdata_in, acc, bit_sel_in,
                                     mask_lo);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_pin_data             <= `TBP_RST_LATCH;
      port_direction            <= `TBP_RST_DIRECTION;
      alternate_mode_select     <= `TBP_RST_ALT_SELECT;
      port_or_alternate_control <= `TBP_RST_PORT_ALT;
      output_drive_type         <= `TBP_RST_DRIVE_TYPE;
      pullup_option             <= `TBP_RST_PULLUP;
      rdata_out                 <= 8'h00;
    end else if (ce_in) begin
      port_pin_data             <= next_port_pin_data;
      port_direction            <= next_port_direction;
      alternate_mode_select     <= next_alternate_mode_select;
      port_or_alternate_control <= next_port_or_alternate_control;
      output_drive_type         <= next_output_drive_type;
      pullup_option             <= next_pullup_option;
      rdata_out                 <= next_rdata;
    end
  end

  // ==========================================================
  // Peripheral routing per pin
  logic [2:0] periph_o;
  logic [2:0] periph_oe;
  logic [2:0] cell_o;
  logic [2:0] cell_oe;
  logic       next_s1_in;
  logic       next_rx;
  logic       next_sck;

  always_comb begin
    periph_o  = 3'h0;
    periph_oe = 3'h0;
    // Pin 0 is input-only in alternate mode
    periph_o[`TBP_PIN_TX]   = alternate_mode_select[`TBP_PIN_TX] ?
                              uart0_transmit_in : serial1_data_out_in;
    periph_oe[`TBP_PIN_TX]  = alternate_mode_select[`TBP_PIN_TX] ?
                              1'b1 : serial1_data_oe_in;
    periph_o[`TBP_PIN_SCK]  = serial0_clock_out_in;
    periph_oe[`TBP_PIN_SCK] = serial0_clock_oe_in;
    next_s1_in = port_or_alternate_control[`TBP_PIN_RX] &
                 ~alternate_mode_select[`TBP_PIN_RX] & pin_in[`TBP_PIN_RX];
    next_rx    = ~(port_or_alternate_control[`TBP_PIN_RX] &
                   alternate_mode_select[`TBP_PIN_RX]) | pin_in[`TBP_PIN_RX];
    next_sck   = port_or_alternate_control[`TBP_PIN_SCK] & pin_in[`TBP_PIN_SCK];
  end

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      tbp_pin_cell u_cell (
        .port_alt_in   (port_or_alternate_control[g]),
        .dir_in        (port_direction[g]),
        .open_drain_in (output_drive_type[g]),
        .latch_in      (port_pin_data[g]),
        .periph_out_in (periph_o[g]),
        .periph_oe_in  (periph_oe[g]),
        .pad_o_out     (cell_o[g]),
        .pad_oe_out    (cell_oe[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_out              <= 3'h0;
      pin_oe_out           <= 3'h0;
      pullup_en_out        <= 3'h0;
      serial1_data_in_out  <= 1'b0;
      uart0_receive_out    <= 1'b1;
      serial0_clock_in_out <= 1'b0;
    end else if (ce_in) begin
      pin_out              <= cell_o;
      pin_oe_out           <= cell_oe;
      pullup_en_out        <= pullup_option[2:0];
      serial1_data_in_out  <= next_s1_in;
      uart0_receive_out    <= next_rx;
      serial0_clock_in_out <= next_sck;
    end
  end

  // ==========================================================
  // Checks
  AST_DIR_UPPER: assert property (@(posedge clk_in) disable iff (!rstn_in)
    port_direction[7:3] == 5'h1f) else $error("direction upper bits not one");
  AST_OUT_DRIVE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in && !port_or_alternate_control[0] && !port_direction[0]
    |=> pin_oe_out[0] && pin_out[0] == $past(port_pin_data[0]))
    else $error("output pin not driven from latch");
  AST_IN_NODRIVE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in && !port_or_alternate_control[1] && port_direction[1] |=> !pin_oe_out[1])
    else $error("input pin driven");
  AST_OD_HIGH: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in && output_drive_type[1] && cell_o[1] |=> !pin_oe_out[1])
    else $error("open drain drove high");
  AST_DRV_MASK: assert property (@(posedge clk_in) disable iff (!rstn_in)
    output_drive_type[0] == 1'b0 && output_drive_type[7:3] == 5'h00)
    else $error("drive type reserved bit set");
  AST_PULL: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in |=> pullup_en_out == $past(pullup_option[2:0]))
    else $error("pull-up output mismatch");
  AST_BITWR: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in && wr_in && bit_acc_in && decode(addr_in) == tbp_pkg::TBP_REG_PULL
    && bit_sel_in < 3'h3 |=> pullup_option[$past(bit_sel_in)] == $past(wdata_in[0]))
    else $error("single-bit write lost");
  AST_TX_SEL: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in && port_or_alternate_control[1] && alternate_mode_select[1]
    && !output_drive_type[1] |=> pin_oe_out[1] && pin_out[1] == $past(uart0_transmit_in))
    else $error("uart transmit not routed");
  AST_RX_SEL: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in && port_or_alternate_control[0] && alternate_mode_select[0]
    |=> uart0_receive_out == $past(pin_in[0]))
    else $error("uart receive not routed");
  AST_SCK: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in && port_or_alternate_control[2] |=> serial0_clock_in_out == $past(pin_in[2]))
    else $error("serial clock not routed");
  AST_MODE: assert property (@(posedge clk_in) disable iff (!rstn_in)
    port_or_alternate_control[7:3] == 5'h00) else $error("mode reserved bits set");
  AST_LATCH: assert property (@(posedge clk_in) disable iff (!rstn_in)
    ce_in && wr_in && !bit_acc_in && decode(addr_in) == tbp_pkg::TBP_REG_DATA
    |=> port_pin_data[2:0] == $past(wdata_in[2:0]))
    else $error("latch not written");
  AST_PINS: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pin_read[7:3] == 5'h00) else $error("data upper bits not zero");

endmodule

/* verification/tbp_pad_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Pads as seen from the board: design drive, outside driver, pull-up
module tbp_pad_model (
  // Clock
  input  wire logic       clk_in,
  // Design side of the pads
  input  wire logic [2:0] pin_out_in,
  input  wire logic [2:0] pin_oe_in,
  input  wire logic [2:0] pullup_en_in,
  // Outside driver
  input  wire logic [2:0] ext_en_in,
  input  wire logic [2:0] ext_val_in,
  // Resolved level
  output logic      [2:0] level_out
);
  logic flip = 1'b0;

  always @(posedge clk_in) begin
    flip <= ~flip;
  end

  // A floating pad shows a level that changes every cycle
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe_in[i]) begin
        level_out[i] = pin_out_in[i];
      end else if (ext_en_in[i]) begin
        level_out[i] = ext_val_in[i];
      end else if (pullup_en_in[i]) begin
        level_out[i] = 1'b1;
      end else begin
        level_out[i] = flip ^ i[0];
      end
    end
  end
endmodule

/* verification/three_bit_port_with_alternates_test.sv */
`timescale 1ns/1ps
`include "tbp_port_map.svh"
module three_bit_port_with_alternates_test;
  // ==========================================================
  // Signals
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        bit_acc_in = 1'b0;
  logic [2:0]  bit_sel_in = 3'h0;
  logic [31:0] addr_in = 32'h00000000;
  logic [7:0]  wdata_in = 8'h00;
  logic [7:0]  rdata_out;
  logic [2:0]  pin_in;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe_out;
  logic [2:0]  pullup_en_out;
  logic        s1_do = 1'b0;
  logic        s1_oe = 1'b0;
  logic        u_tx = 1'b1;
  logic        sck_o = 1'b0;
  logic        sck_oe = 1'b0;
  logic        s1_di;
  logic        u_rx;
  logic        sck_i;
  logic [2:0]  ext_en = 3'h0;
  logic [2:0]  ext_val = 3'h0;
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  always #4 clk_in = ~clk_in;

  tbp_port u_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .bit_acc_in(bit_acc_in),
    .bit_sel_in(bit_sel_in), .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe_out), .pullup_en_out(pullup_en_out),
    .serial1_data_out_in(s1_do), .serial1_data_oe_in(s1_oe), .uart0_transmit_in(u_tx),
    .serial0_clock_out_in(sck_o), .serial0_clock_oe_in(sck_oe),
    .serial1_data_in_out(s1_di), .uart0_receive_out(u_rx), .serial0_clock_in_out(sck_i)
  );

  tbp_pad_model u_pads (
    .clk_in(clk_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
    .pullup_en_in(pullup_en_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(pin_in)
  );

  // ==========================================================
  // Bus and check tasks
  task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task wr(input logic [31:0] a, input logic [7:0] d, input logic b = 1'b0,
          input logic [2:0] s = 3'h0);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    bit_acc_in <= b;
    bit_sel_in <= s;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task rd(input logic [31:0] a, input logic [7:0] e, input logic b = 1'b0,
          input logic [2:0] s = 3'h0);
    @(posedge clk_in);
    addr_in <= a;
    bit_acc_in <= b;
    bit_sel_in <= s;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk("rdata", rdata_out, e);
  endtask

  // Outputs trail the configuration by one registered stage
  task pins(input logic [2:0] oe, input logic [2:0] out);
    repeat (2) @(posedge clk_in);
    #1;
    chk("pin_oe", {5'h00, pin_oe_out}, {5'h00, oe});
    chk("pin_out", {5'h00, pin_out & oe}, {5'h00, out});
  endtask

  task test_done;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      test_done();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(`TBP_ADDR_DIRECTION, 8'hff);
    rd(`TBP_ADDR_ALT_SELECT, 8'h00);
    rd(`TBP_ADDR_PORT_ALT, 8'h00);
    rd(`TBP_ADDR_DRIVE_TYPE, 8'h00);
    rd(`TBP_ADDR_PULLUP, 8'h00);
    rd(32'hfffff400, 8'h00);
    pins(3'h0, 3'h0);
    wr(`TBP_ADDR_PULLUP, 8'hff);
    rd(`TBP_ADDR_PULLUP, 8'h07);
    chk("pullup_en", {5'h00, pullup_en_out}, 8'h07);
    wr(`TBP_ADDR_PIN_DATA, 8'h05);
    pins(3'h0, 3'h0);
    rd(`TBP_ADDR_PIN_DATA, 8'h07);
    @(posedge clk_in);
    ext_en <= 3'h7;
    ext_val <= 3'h2;
    rd(`TBP_ADDR_PIN_DATA, 8'h02);
    wr(`TBP_ADDR_DIRECTION, 8'h00);
    rd(`TBP_ADDR_DIRECTION, 8'hf8);
    pins(3'h7, 3'h5);
    rd(`TBP_ADDR_PIN_DATA, 8'h05);
    @(posedge clk_in);
    ext_en <= 3'h0;
    // Single-bit accesses
    wr(`TBP_ADDR_DIRECTION, 8'h01, 1'b1, 3'h1);
    rd(`TBP_ADDR_DIRECTION, 8'hfa);
    pins(3'h5, 3'h5);
    rd(`TBP_ADDR_PIN_DATA, 8'h01, 1'b1, 3'h2);
    wr(`TBP_ADDR_PIN_DATA, 8'h01, 1'b1, 3'h1);
    wr(`TBP_ADDR_DIRECTION, 8'h00, 1'b1, 3'h1);
    pins(3'h7, 3'h7);
    // Open drain on pins 1 and 2
    wr(`TBP_ADDR_PIN_DATA, 8'h04);
    wr(`TBP_ADDR_DRIVE_TYPE, 8'hff);
    rd(`TBP_ADDR_DRIVE_TYPE, 8'h06);
    pins(3'h3, 3'h0);
    // Alternate functions, control mode 2
    wr(`TBP_ADDR_DRIVE_TYPE, 8'h00);
    wr(`TBP_ADDR_PORT_ALT, 8'hff);
    rd(`TBP_ADDR_PORT_ALT, 8'h07);
    wr(`TBP_ADDR_ALT_SELECT, 8'hff);
    rd(`TBP_ADDR_ALT_SELECT, 8'h03);
    @(posedge clk_in);
    u_tx <= 1'b0;
    sck_o <= 1'b1;
    sck_oe <= 1'b1;
    ext_en <= 3'h1;
    ext_val <= 3'h0;
    pins(3'h6, 3'h4);
    chk("uart_rx", {7'h00, u_rx}, 8'h00);
    chk("serial1_in", {7'h00, s1_di}, 8'h00);
    chk("sck_in", {7'h00, sck_i}, 8'h01);
    // Control mode 1
    wr(`TBP_ADDR_ALT_SELECT, 8'h00);
    s1_do <= 1'b1;
    s1_oe <= 1'b1;
    ext_val <= 3'h1;
    pins(3'h6, 3'h6);
    chk("serial1_in", {7'h00, s1_di}, 8'h01);
    chk("uart_rx", {7'h00, u_rx}, 8'h01);
    wr(`TBP_ADDR_DRIVE_TYPE, 8'h02);
    pins(3'h4, 3'h4);
    wr(`TBP_ADDR_PORT_ALT, 8'h00);
    pins(3'h7, 3'h4);
    // Clock enable low freezes state, then a single-bit pull-up write
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(`TBP_ADDR_PULLUP, 8'h00);
    ce_in <= 1'b1;
    rd(`TBP_ADDR_PULLUP, 8'h07);
    wr(`TBP_ADDR_PULLUP, 8'h00, 1'b1, 3'h1);
    rd(`TBP_ADDR_PULLUP, 8'h05);
    chk("pullup_en", {5'h00, pullup_en_out}, 8'h05);
    test_done();
  end
endmodule
